/* File: verilog/special_cmd_regs.v */
`timescale 1ns/1ps
`default_nettype none
`include "special_cmd_defs.vh"

// Overview of operation
// - refresh count is read-only, high byte at 0xC4, low byte at 0xC5
// - 8 to 150 stored writes per refresh; ascending address order gives most
// - indicator byte at 0xC6, read with size 0x03, two escapes, address 0x46
// - bit0 exception, bit1 transmitter active, bit2 receiver active, bit3 undefined
// - bit4 rf transfer, bit5 serial buffer empty, bit6 ack received, bit7 zero
// - command register 0xC7 is write-only, escape then 0x47, value selects operation
// - decode 0x10 join, 0x11 write, 0x12 clear, 0x13 reload, 0x20 AA BB reset
// - join subcommand 0 halts, 1 generates key and admin role, 2 starts join
// - serial-started join makes push-button input ignored until join ends
// - writes rejected during join except halt-join, which is always accepted
// - halt-join completes fully before the acknowledgement goes out
// - key-receive flag at join start selects administrator or node role
// - after successful join, stored address values copied into volatile copies
// - write key carries selector then 16 bytes; 0x01 volatile, 0x02 stored
// - volatile key lost on reset and loaded from stored key at power-up
// - an all-zero key means no key present
// - clear key, size 0x04, value 0x12 then selector, zeroes the selected key
// - reload key copies stored key into the volatile key
// - frame FF 07 FE 47 20 FE 2A FE 3B restores all stored defaults
// - after configuration reset send the framed message, then reset the module
// - push-button restore pattern also performs the factory configuration reset
// - endurance at least 2,000 refreshes; beyond that flag possible misbehaviour
module special_cmd_regs #(
   parameter NV_WRITES_PER_REFRESH = `NV_WRITES_MIN
) (
   input wire i_ref_clk,
   input wire i_arst_n,
   input wire [7:0] i_rx_data,
   input wire i_rx_valid,
   output wire o_rx_ready,
   output reg [7:0] o_tx_data,
   output reg o_tx_valid,
   input wire i_tx_ready,
   input wire i_exception_flag,
   input wire i_transmitter_active,
   input wire i_receiver_active,
   input wire i_rf_transfer_active,
   input wire i_serial_buffer_empty,
   input wire i_ack_received,
   input wire i_join_active,
   input wire i_join_done,
   input wire i_join_success,
   input wire i_key_receive_flag,
   input wire i_pb_restore,
   output wire o_push_button_enable,
   output wire o_write_inhibit,
   output reg o_join_halt,
   output reg o_join_generate,
   output reg o_join_start,
   output reg o_key_receive_clear,
   output reg o_join_admin_role,
   output reg o_nv_to_volatile_copy,
   output reg [127:0] o_working_key,
   output reg [127:0] o_stored_key,
   output reg o_working_key_present,
   output reg o_stored_key_present,
   output reg [15:0] o_refresh_count,
   output reg o_nv_refresh,
   output reg o_endurance_exceeded,
   output reg o_module_reset
);

   localparam [2:0] S_HDR = 3'h0;
   localparam [2:0] S_SIZE = 3'h1;
   localparam [2:0] S_BODY = 3'h2;
   localparam [2:0] S_EXEC = 3'h3;
   localparam [2:0] S_HALT_WAIT = 3'h4;
   localparam [2:0] S_TX = 3'h5;

   reg [1:0] rst_sync_q;
   wire rst_n;
   reg [2:0] state_q;
   reg [7:0] raw_left_q;
   reg first_q;
   reg marker_q;
   reg esc_q;
   reg ovf_q;
   reg [4:0] cnt_q;
   reg [7:0] buf_q [0:`FRAME_BUF_DEPTH-1];
   reg [7:0] resp_addr_q;
   reg [7:0] resp_val_q;
   reg [4:0] tx_len_q;
   reg [4:0] tx_idx_q;
   reg msg_mode_q;
   reg serial_join_q;
   reg key_load_q;
   reg [7:0] nv_writes_q;
   reg nv_write;
   reg [7:0] dec_byte;
   reg [7:0] waddr;
   wire rx_take;
   wire [4:0] tx_next;
   integer i;

   // ======================================================
   // message text sent after a configuration reset
   function [7:0] msg_char;
      input [4:0] idx;
      begin
         case (idx)
            5'h00: msg_char = 8'h0D;
            5'h01: msg_char = 8'h0A;
            5'h02: msg_char = 8'h43;
            5'h03: msg_char = 8'h6F;
            5'h04: msg_char = 8'h6E;
            5'h05: msg_char = 8'h66;
            5'h06: msg_char = 8'h69;
            5'h07: msg_char = 8'h67;
            5'h08: msg_char = 8'h75;
            5'h09: msg_char = 8'h72;
            5'h0A: msg_char = 8'h61;
            5'h0B: msg_char = 8'h74;
            5'h0C: msg_char = 8'h69;
            5'h0D: msg_char = 8'h6F;
            5'h0E: msg_char = 8'h6E;
            5'h0F: msg_char = 8'h20;
            5'h10: msg_char = 8'h52;
            5'h11: msg_char = 8'h65;
            5'h12: msg_char = 8'h73;
            5'h13: msg_char = 8'h65;
            5'h14: msg_char = 8'h74;
            5'h15: msg_char = 8'h0D;
            default: msg_char = 8'h0A;
         endcase
      end
   endfunction

   // byte to send at a position of the current answer
   function [7:0] tx_byte;
      input [4:0] idx;
      input msg;
      input [7:0] addr;
      input [7:0] val;
      begin
         if (msg) begin
            tx_byte = msg_char(idx);
         end else if (idx == 5'h00) begin
            tx_byte = `ACK_BYTE;
         end else if (idx == 5'h01) begin
            tx_byte = addr;
         end else begin
            tx_byte = val;
         end
      end
   endfunction

   // ======================================================
   // reset release: asynchronous assert, two-flop release
   always @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   assign rx_take = i_rx_valid && o_rx_ready;
   assign o_rx_ready = (state_q == S_HDR) || (state_q == S_SIZE) || (state_q == S_BODY);
   assign o_push_button_enable = !serial_join_q;
   assign o_write_inhibit = i_join_active;
   assign tx_next = tx_idx_q + 5'h01;

   // incoming byte after escape removal; an escape marks the next byte as +0x80
   always @* begin
      dec_byte = esc_q ? (i_rx_data + `ESC_OFFSET) : i_rx_data;
      waddr = marker_q ? (buf_q[0] | `ESC_OFFSET) : buf_q[0];
   end

   // ======================================================
   // frame parser, command executor and answer sender
   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_HDR;
         raw_left_q <= 8'h00;
         first_q <= 1'b0;
         marker_q <= 1'b0;
         esc_q <= 1'b0;
         ovf_q <= 1'b0;
         cnt_q <= 5'h00;
         for (i = 0; i < `FRAME_BUF_DEPTH; i = i + 1) begin
            buf_q[i] <= 8'h00;
         end
         resp_addr_q <= 8'h00;
         resp_val_q <= 8'h00;
         tx_len_q <= 5'h00;
         tx_idx_q <= 5'h00;
         msg_mode_q <= 1'b0;
         serial_join_q <= 1'b0;
         key_load_q <= 1'b1;
         o_tx_data <= 8'h00;
         o_tx_valid <= 1'b0;
         o_join_halt <= 1'b0;
         o_join_generate <= 1'b0;
         o_join_start <= 1'b0;
         o_key_receive_clear <= 1'b0;
         o_join_admin_role <= 1'b0;
         o_nv_to_volatile_copy <= 1'b0;
         o_working_key <= 128'h0;
         o_stored_key <= 128'h0;
         o_module_reset <= 1'b0;
         nv_write <= 1'b0;
      end else begin
         o_join_halt <= 1'b0;
         o_join_generate <= 1'b0;
         o_join_start <= 1'b0;
         o_key_receive_clear <= 1'b0;
         o_nv_to_volatile_copy <= 1'b0;
         o_module_reset <= 1'b0;
         nv_write <= 1'b0;
         // power-up or module reset loads the volatile key from the stored one
         if (key_load_q) begin
            o_working_key <= o_stored_key;
            key_load_q <= 1'b0;
         end
         if (i_join_done) begin
            serial_join_q <= 1'b0;
            o_nv_to_volatile_copy <= i_join_success;
         end
         case (state_q)
            S_HDR: begin
               if (rx_take && (i_rx_data == `FRAME_HDR)) begin
                  state_q <= S_SIZE;
               end else if (i_pb_restore && !serial_join_q) begin
                  o_stored_key <= 128'h0;
                  o_working_key <= 128'h0;
                  nv_write <= 1'b1;
                  msg_mode_q <= 1'b1;
                  tx_len_q <= `MSG_LEN;
                  tx_idx_q <= 5'h00;
                  o_tx_data <= msg_char(5'h00);
                  o_tx_valid <= 1'b1;
                  state_q <= S_TX;
               end
            end
            S_SIZE: begin
               if (rx_take) begin
                  raw_left_q <= i_rx_data;
                  first_q <= 1'b1;
                  marker_q <= 1'b0;
                  esc_q <= 1'b0;
                  ovf_q <= 1'b0;
                  cnt_q <= 5'h00;
                  if (i_rx_data == 8'h00 || i_rx_data == `FRAME_HDR) begin
                     state_q <= S_HDR;
                  end else begin
                     state_q <= S_BODY;
                  end
               end
            end
            S_BODY: begin
               if (rx_take) begin
                  raw_left_q <= raw_left_q - 8'h01;
                  first_q <= 1'b0;
                  if (i_rx_data == `FRAME_HDR) begin
                     // a raw header can only start a new frame: resynchronise
                     state_q <= S_SIZE;
                  end else begin
                     if (first_q && i_rx_data == `ESC_BYTE) begin
                        marker_q <= 1'b1;
                     end else if (!esc_q && i_rx_data == `ESC_BYTE) begin
                        esc_q <= 1'b1;
                     end else begin
                        esc_q <= 1'b0;
                        if (cnt_q < `FRAME_BUF_DEPTH) begin
                           buf_q[cnt_q] <= dec_byte;
                           cnt_q <= cnt_q + 5'h01;
                        end else begin
                           ovf_q <= 1'b1;
                        end
                     end
                     if (raw_left_q == 8'h01) begin
                        state_q <= S_EXEC;
                     end
                  end
               end
            end
            S_EXEC: begin
               state_q <= S_HDR;
               msg_mode_q <= 1'b0;
               tx_idx_q <= 5'h00;
               o_tx_data <= `ACK_BYTE;
               if (ovf_q || esc_q || cnt_q == 5'h00) begin
                  state_q <= S_HDR;
               end else if (marker_q && cnt_q == `LEN_READ) begin
                  // read: only the three readable locations of this block answer
                  resp_addr_q <= buf_q[0];
                  tx_len_q <= 5'h03;
                  if (buf_q[0] == `ADDR_REFRESH_HI) begin
                     resp_val_q <= o_refresh_count[15:8];
                     o_tx_valid <= 1'b1;
                     state_q <= S_TX;
                  end else if (buf_q[0] == `ADDR_REFRESH_LO) begin
                     resp_val_q <= o_refresh_count[7:0];
                     o_tx_valid <= 1'b1;
                     state_q <= S_TX;
                  end else if (buf_q[0] == `ADDR_IND_STATE) begin
                     // undefined bit 3 reads as zero
                     resp_val_q <= {1'b0, i_ack_received, i_serial_buffer_empty,
                        i_rf_transfer_active, 1'b0, i_receiver_active,
                        i_transmitter_active, i_exception_flag};
                     o_tx_valid <= 1'b1;
                     state_q <= S_TX;
                  end
               end else if (waddr == `ADDR_SPECIAL_CMD && cnt_q >= `LEN_RELOAD) begin
                  tx_len_q <= 5'h01;
                  if (i_join_active && !(buf_q[1] == `CMD_JOIN_CONTROL &&
                        cnt_q == `LEN_JOIN_CLEAR && buf_q[2] == `JOIN_HALT)) begin
                     state_q <= S_HDR;
                  end else begin
                     case (buf_q[1])
                        `CMD_JOIN_CONTROL: begin
                           if (cnt_q == `LEN_JOIN_CLEAR && buf_q[2] == `JOIN_HALT) begin
                              o_join_halt <= 1'b1;
                              state_q <= S_HALT_WAIT;
                           end else if (cnt_q == `LEN_JOIN_CLEAR &&
                                 buf_q[2] == `JOIN_GENERATE) begin
                              o_join_generate <= 1'b1;
                              o_key_receive_clear <= 1'b1;
                              o_join_admin_role <= 1'b1;
                              o_tx_valid <= 1'b1;
                              state_q <= S_TX;
                           end else if (cnt_q == `LEN_JOIN_CLEAR &&
                                 buf_q[2] == `JOIN_START) begin
                              o_join_start <= 1'b1;
                              serial_join_q <= 1'b1;
                              o_join_admin_role <= !i_key_receive_flag;
                              o_tx_valid <= 1'b1;
                              state_q <= S_TX;
                           end
                        end
                        `CMD_WRITE_KEY: begin
                           if (cnt_q == `LEN_WRITE_KEY && (buf_q[2] == `SEL_WORKING_KEY ||
                                 buf_q[2] == `SEL_STORED_KEY)) begin
                              // first key byte lands in the top byte of the key
                              for (i = 0; i < 16; i = i + 1) begin
                                 if (buf_q[2] == `SEL_WORKING_KEY) begin
                                    o_working_key[127-8*i -: 8] <= buf_q[`KEY_FIRST_IDX+i];
                                 end else begin
                                    o_stored_key[127-8*i -: 8] <= buf_q[`KEY_FIRST_IDX+i];
                                 end
                              end
                              nv_write <= (buf_q[2] == `SEL_STORED_KEY);
                              o_tx_valid <= 1'b1;
                              state_q <= S_TX;
                           end
                        end
                        `CMD_CLEAR_KEY: begin
                           if (cnt_q == `LEN_JOIN_CLEAR && buf_q[2] == `SEL_WORKING_KEY) begin
                              o_working_key <= 128'h0;
                              o_tx_valid <= 1'b1;
                              state_q <= S_TX;
                           end else if (cnt_q == `LEN_JOIN_CLEAR &&
                                 buf_q[2] == `SEL_STORED_KEY) begin
                              o_stored_key <= 128'h0;
                              nv_write <= 1'b1;
                              o_tx_valid <= 1'b1;
                              state_q <= S_TX;
                           end
                        end
                        `CMD_RELOAD_KEY: begin
                           if (cnt_q == `LEN_RELOAD) begin
                              o_working_key <= o_stored_key;
                              o_tx_valid <= 1'b1;
                              state_q <= S_TX;
                           end
                        end
                        `CMD_FACTORY_RESET: begin
                           if (cnt_q == `LEN_FACTORY && buf_q[2] == `FACTORY_ARG1 &&
                                 buf_q[3] == `FACTORY_ARG2) begin
                              o_stored_key <= 128'h0;
                              o_working_key <= 128'h0;
                              nv_write <= 1'b1;
                              msg_mode_q <= 1'b1;
                              tx_len_q <= `MSG_LEN;
                              o_tx_data <= msg_char(5'h00);
                              o_tx_valid <= 1'b1;
                              state_q <= S_TX;
                           end
                        end
                        default: begin
                           state_q <= S_HDR;
                        end
                     endcase
                  end
               end
            end
            S_HALT_WAIT: begin
               // the acknowledgement waits until the join has really stopped
               if (!i_join_active) begin
                  o_tx_valid <= 1'b1;
                  state_q <= S_TX;
               end
            end
            S_TX: begin
               if (o_tx_valid && i_tx_ready) begin
                  tx_idx_q <= tx_next;
                  if (tx_next == tx_len_q) begin
                     o_tx_valid <= 1'b0;
                     state_q <= S_HDR;
                     if (msg_mode_q) begin
                        o_module_reset <= 1'b1;
                        serial_join_q <= 1'b0;
                        key_load_q <= 1'b1;
                     end
                  end else begin
                     o_tx_data <= tx_byte(tx_next, msg_mode_q, resp_addr_q, resp_val_q);
                  end
               end
            end
            default: begin
               state_q <= S_HDR;
            end
         endcase
      end
   end

   // ======================================================
   // lifetime refresh counter: write order within a refresh window is not
   // modelled, so the fixed per-refresh budget is the pessimistic figure
   always @(posedge i_ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_writes_q <= 8'h00;
         o_refresh_count <= 16'h0000;
         o_nv_refresh <= 1'b0;
         o_endurance_exceeded <= 1'b0;
         o_working_key_present <= 1'b0;
         o_stored_key_present <= 1'b0;
      end else begin
         o_nv_refresh <= 1'b0;
         if (nv_write) begin
            if (nv_writes_q == NV_WRITES_PER_REFRESH[7:0] - 8'h01) begin
               nv_writes_q <= 8'h00;
               o_nv_refresh <= 1'b1;
               if (o_refresh_count != 16'hFFFF) begin
                  o_refresh_count <= o_refresh_count + 16'h0001;
               end
            end else begin
               nv_writes_q <= nv_writes_q + 8'h01;
            end
         end
         o_endurance_exceeded <= (o_refresh_count >= `ENDURANCE_MIN);
         o_working_key_present <= |o_working_key;
         o_stored_key_present <= |o_stored_key;
      end
   end

endmodule
`default_nettype wire

/* File: verilog/special_cmd_defs.vh */
`ifndef SPECIAL_CMD_DEFS_VH
`define SPECIAL_CMD_DEFS_VH
// ======================================================
// frame bytes
`define FRAME_HDR 8'hFF
`define ESC_BYTE 8'hFE
`define ESC_OFFSET 8'h80
`define ACK_BYTE 8'h06
// ======================================================
// register locations
`define ADDR_REFRESH_HI 8'hC4
`define ADDR_REFRESH_LO 8'hC5
`define ADDR_IND_STATE 8'hC6
`define ADDR_SPECIAL_CMD 8'hC7
// ======================================================
// special command values and arguments
`define CMD_JOIN_CONTROL 8'h10
`define CMD_WRITE_KEY 8'h11
`define CMD_CLEAR_KEY 8'h12
`define CMD_RELOAD_KEY 8'h13
`define CMD_FACTORY_RESET 8'h20
`define FACTORY_ARG1 8'hAA
`define FACTORY_ARG2 8'hBB
`define JOIN_HALT 8'h00
`define JOIN_GENERATE 8'h01
`define JOIN_START 8'h02
`define SEL_WORKING_KEY 8'h01
`define SEL_STORED_KEY 8'h02
// ======================================================
// decoded byte counts of each frame kind
`define LEN_READ 5'h01
`define LEN_RELOAD 5'h02
`define LEN_JOIN_CLEAR 5'h03
`define LEN_FACTORY 5'h04
`define LEN_WRITE_KEY 5'h13
`define FRAME_BUF_DEPTH 20
`define KEY_FIRST_IDX 3
// ======================================================
// indicator line state byte bit positions
`define IND_EXC_BIT 0
`define IND_TX_BIT 1
`define IND_RX_BIT 2
`define IND_RF_BIT 4
`define IND_BE_BIT 5
`define IND_ACK_BIT 6
// ======================================================
// non-volatile store limits and message length
`define NV_WRITES_MIN 8
`define NV_WRITES_MAX 150
`define ENDURANCE_MIN 16'h07D0
`define MSG_LEN 5'h17
`endif

/* File: verif/special_cmd_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// port checks of this block
module special_cmd_regs_sva (
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   input wire logic i_tx_ready,
   input wire logic i_join_active,
   input wire logic i_join_done,
   input wire logic i_join_success,
   input wire logic o_rx_ready,
   input wire logic [7:0] o_tx_data,
   input wire logic o_tx_valid,
   input wire logic o_write_inhibit,
   input wire logic o_join_halt,
   input wire logic o_join_generate,
   input wire logic o_join_start,
   input wire logic o_join_admin_role,
   input wire logic o_push_button_enable,
   input wire logic o_nv_to_volatile_copy,
   input wire logic [127:0] o_working_key,
   input wire logic o_working_key_present
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_arst_n);
   // halt while the join runs: ack waits
   sequence halt_pending; o_join_halt ##1 i_join_active; endsequence
   sequence tx_stalled; o_tx_valid && !i_tx_ready; endsequence
   a_tx_holds_byte: assert property (tx_stalled |=> o_tx_valid && $stable(o_tx_data))
      else $error("answer byte moved while stalled");
   a_busy_answering: assert property (o_tx_valid |-> !o_rx_ready)
      else $error("bytes taken during an answer");
   a_inhibit_tracks: assert property ($past(o_write_inhibit) |->
      !o_join_generate && !o_join_start) else $error("join pulse during inhibit");
   a_halt_ack_waits: assert property (halt_pending |-> !o_tx_valid)
      else $error("halt acknowledged before join ended");
   a_generate_admin: assert property (o_join_generate |-> ##[0:1] o_join_admin_role)
      else $error("generate did not set administrator role");
   a_start_locks_pb: assert property (o_join_start |-> ##[0:1] !o_push_button_enable)
      else $error("button still enabled after serial join start");
   a_copy_after_join: assert property (i_join_done && i_join_success |=> o_nv_to_volatile_copy)
      else $error("no copy after successful join");
   a_key_presence: assert property (o_working_key_present == ($past(o_working_key) != 128'h0))
      else $error("key presence flag wrong");
endmodule
bind special_cmd_regs special_cmd_regs_sva chk (.i_ref_clk, .i_arst_n, .i_tx_ready,
   .i_join_active, .i_join_done, .i_join_success, .o_rx_ready, .o_tx_data, .o_tx_valid,
   .o_write_inhibit, .o_join_halt, .o_join_generate, .o_join_start, .o_join_admin_role,
   .o_push_button_enable, .o_nv_to_volatile_copy, .o_working_key, .o_working_key_present);
`default_nettype wire

/* File: verif/host_uart_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// host side: sends frames, collects answer bytes
module host_uart_model (
   input wire logic i_clk,
   input wire logic i_ready,
   input wire logic [7:0] i_data,
   input wire logic i_valid,
   output logic [7:0] o_data,
   output logic o_valid,
   output logic o_accept
);
   logic [7:0] got[$];
   int stall = 0;
   int held = 0;
   initial begin
      o_data = 8'h00;
      o_valid = 1'b0;
      o_accept = 1'b0;
   end
   // a slow host waits stall cycles per byte
   always @(negedge i_clk) begin
      o_accept <= i_valid && !o_accept && held >= stall;
      held <= (i_valid && !o_accept) ? held + 1 : 0;
   end
   always @(posedge i_clk) if (i_valid && o_accept) got.push_back(i_data);
   // released data shows its inverse
   task automatic send(input logic [7:0] d);
      @(negedge i_clk);
      o_data = d;
      o_valid = 1'b1;
      do @(posedge i_clk); while (!i_ready);
      @(negedge i_clk);
      o_valid = 1'b0;
      o_data = ~d;
   endtask
   task automatic frame(input logic [7:0] body[$]);
      got = {};
      send(8'hFF);
      send(8'(body.size()));
      foreach (body[i]) send(body[i]);
   endtask
endmodule
`default_nettype wire

/* File: verif/special_cmd_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ======================================================
// frame-level tests of the special command block
module special_cmd_regs_bench;
   logic i_ref_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic mreset_seen = 1'b0;
   logic [7:0] i_rx_data, o_tx_data, ind, b[$];
   logic i_rx_valid, o_rx_ready, o_tx_valid, i_tx_ready, o_push_button_enable;
   logic i_join_active, i_join_done, i_join_success, i_key_receive_flag, o_join_admin_role;
   logic o_module_reset, o_working_key_present, i_pb_restore;
   logic [127:0] o_working_key, o_stored_key;
   int failures = 0;
   int tests_run = 0;
   int cycles = 0;
   string msg = "\r\nConfiguration Reset\r\n";
   special_cmd_regs uut (.i_ref_clk, .i_arst_n, .i_rx_data, .i_rx_valid, .o_rx_ready,
      .o_tx_data, .o_tx_valid, .i_tx_ready, .i_exception_flag(ind[0]),
      .i_transmitter_active(ind[1]), .i_receiver_active(ind[2]), .i_rf_transfer_active(ind[4]),
      .i_serial_buffer_empty(ind[5]), .i_ack_received(ind[6]), .i_join_active, .i_join_done,
      .i_join_success, .i_key_receive_flag, .i_pb_restore, .o_push_button_enable,
      .o_write_inhibit(), .o_join_halt(), .o_join_generate(), .o_join_start(),
      .o_key_receive_clear(), .o_join_admin_role, .o_nv_to_volatile_copy(), .o_working_key,
      .o_stored_key, .o_working_key_present, .o_stored_key_present(), .o_refresh_count(),
      .o_nv_refresh(), .o_endurance_exceeded(), .o_module_reset);
   host_uart_model host (.i_clk(i_ref_clk), .i_ready(o_rx_ready), .i_data(o_tx_data),
      .i_valid(o_tx_valid), .o_data(i_rx_data), .o_valid(i_rx_valid), .o_accept(i_tx_ready));
   // clock; the ceiling ends a hung run
   always #2 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      cycles <= cycles + 1;
      if (o_module_reset === 1'b1) mreset_seen <= 1'b1;
      if (cycles == 20000) begin
         failures++;
         results();
      end
   end
   task automatic check(input logic [128:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // wait for n answer bytes, then a margin for strays
   task automatic ans(input int n);
      repeat (300) if (host.got.size() < n) @(posedge i_ref_clk);
      repeat (6) @(negedge i_ref_clk);
      check(host.got.size(), n);
      if (n == 1) check(host.got[0], 8'h06);
   endtask
   task automatic rd(input logic [7:0] a, x);
      host.frame({8'hFE, 8'hFE, a - 8'h80});
      ans(3);
      check({host.got[0], host.got[1], host.got[2]}, {8'h06, a, x});
   endtask
   task automatic results;
      $display("compares %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      ind = 8'h00;
      {i_pb_restore, i_join_active, i_join_done, i_join_success, i_key_receive_flag} = 5'h00;
      repeat (8) @(negedge i_ref_clk);
      i_arst_n = 1'b1;
      repeat (3) @(negedge i_ref_clk);
      check(o_working_key | o_stored_key, 129'h0);
      rd(8'hC4, 8'h00);
      rd(8'hC5, 8'h00);
      for (int p = 8'h25; p < 9'h100; p += 8'h6D) begin
         ind = 8'(p);
         rd(8'hC6, 8'(p) & 8'h77);
      end
      $display("test status reads done");
      // key bytes count up from 0x10 times the selector
      for (int s = 1; s <= 2; s++) begin
         b = {8'hFE, 8'h47, 8'h11, 8'(s)};
         for (int i = 0; i < 16; i++) b.push_back(8'(16 * s + i));
         host.frame(b);
         ans(1);
      end
      check(o_working_key, 128'h101112131415161718191A1B1C1D1E1F);
      check(o_stored_key, 128'h202122232425262728292A2B2C2D2E2F);
      check(o_working_key_present, 1'b1);
      host.frame({8'hFE, 8'h47, 8'h12, 8'h01});
      ans(1);
      check(o_working_key, 128'h0);
      host.frame({8'hFE, 8'h47, 8'h13});
      ans(1);
      check(o_working_key, 128'h202122232425262728292A2B2C2D2E2F);
      $display("test keys done");
      host.frame({8'hFE, 8'h47, 8'h10, 8'h01});
      ans(1);
      check(o_join_admin_role, 1'b1);
      i_key_receive_flag = 1'b1;
      host.frame({8'hFE, 8'h47, 8'h10, 8'h02});
      ans(1);
      check({o_join_admin_role, o_push_button_enable}, 2'b00);
      i_join_active = 1'b1;
      host.frame({8'hFE, 8'h47, 8'h12, 8'h02});
      ans(0);
      check(o_stored_key, 128'h202122232425262728292A2B2C2D2E2F);
      host.frame({8'hFE, 8'h47, 8'h10, 8'h00});
      ans(0);
      i_join_active = 1'b0;
      ans(1);
      {i_join_done, i_join_success} = 2'b11;
      @(negedge i_ref_clk);
      i_join_done = 1'b0;
      @(negedge i_ref_clk);
      check(o_push_button_enable, 1'b1);
      $display("test join done");
      host.stall = 2;
      host.frame({8'hFE, 8'h47, 8'h20, 8'hFE, 8'h2A, 8'hFE, 8'h3B});
      ans(23);
      for (int i = 0; i < 23; i++) check(host.got[i], msg[i]);
      check({mreset_seen, o_stored_key}, {1'b1, 128'h0});
      host.got = {};
      i_pb_restore = 1'b1;
      @(negedge i_ref_clk);
      i_pb_restore = 1'b0;
      ans(23);
      $display("test factory reset done");
      results();
   end
endmodule
`default_nettype wire
